// ### include/mcs_pkg.sv
// Constants for the motor overvoltage crowbar supervisor.
// Assumes a 10 MHz system clock; temperature and detection arrive as logic levels.
package mcs_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  // ****************************************
  // Timing figures in their own units
  // ****************************************
  localparam int unsigned SHORT_WAIT_S = 15;
  localparam int unsigned LONG_WAIT_S = 120;
  localparam int unsigned TRIP_HOLD_MIN = 2;
  localparam int unsigned TRIP_LATCH_MS = 10;
  // ****************************************
  // Cycle counts
  // ****************************************
  localparam longint unsigned SHORT_WAIT_CYC = longint'(SHORT_WAIT_S) * CLK_HZ;
  localparam longint unsigned LONG_WAIT_CYC = longint'(LONG_WAIT_S) * CLK_HZ;
  localparam longint unsigned TRIP_HOLD_CYC = longint'(TRIP_HOLD_MIN) * 60 * CLK_HZ;
  localparam longint unsigned TRIP_LATCH_CYC = longint'(TRIP_LATCH_MS) * CLK_HZ / 1000;
  localparam int CNT_W = 32;
  typedef enum logic [1:0] {
    MCS_IDLE,
    MCS_FIRED
  } mcs_fire_t;
endpackage

// ### rtl/mcs_supervisor.sv
// Crowbar supervisor: firing, motor short hold, ready and trip contacts.
// Assumes all inputs synchronous to clk; temperature bands come from comparators.
// Timer lengths are parameters in clock cycles so a bench can shrink them.
// Motor standstill is reported from outside; this block never estimates speed.
// Operation
// - Fire crowbar on phase overvoltage from lost field-weakening current.
// - Fire crowbar to ground on ground-fault overvoltage.
// - Keep short applied until the motor has fully stopped.
// - Forced trip request input fires the crowbar for test.
// - Ready contact closed only while ready, open otherwise.
// - After power-on or test firing below 40C, ready opens 15 s.
// - After power-on or test firing at 40-60C, ready opens 120 s.
// - Above 60C ready stays open until temperature falls below limit.
// - After self-firing ready opens 120 s regardless of temperature.
// - Internal fault opens ready for as long as it persists.
// - Trip contact closes and latches within 10 ms of any firing.
// - Trip contact releases 2 minutes after the last firing.
`timescale 1ns/10ps
module mcs_supervisor #(
  parameter longint unsigned SHORT_WAIT = mcs_pkg::SHORT_WAIT_CYC,
  parameter longint unsigned LONG_WAIT = mcs_pkg::LONG_WAIT_CYC,
  parameter longint unsigned TRIP_HOLD = mcs_pkg::TRIP_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic phaseOverVolt,
  input wire logic groundOverVolt,
  input wire logic forceTrip,
  input wire logic motorStopped,
  input wire logic tempAbove40,
  input wire logic tempAbove60,
  input wire logic internalFault,
  output logic crowbarOn,
  output logic readyContact,
  output logic tripContact
);
  // ****************************************
  // Helpers
  // ****************************************
  // Countdown that parks at zero, shared by the wait and trip timers
  function automatic logic [mcs_pkg::CNT_W-1:0] mcs_count_down(
    input logic [mcs_pkg::CNT_W-1:0] value
  );
    logic [mcs_pkg::CNT_W-1:0] result;
    result = value;
    if (value != '0) begin
      result = value - mcs_pkg::CNT_W'(1);
    end
    return result;
  endfunction

  function automatic logic mcs_timer_done(input logic [mcs_pkg::CNT_W-1:0] value);
    return value == '0;
  endfunction

  // Illegal state codes count as fired so the short stays on the safe side
  function automatic logic mcs_is_idle(input mcs_pkg::mcs_fire_t state);
    return state == mcs_pkg::MCS_IDLE;
  endfunction

  // ****************************************
  // Firing and short hold
  // ****************************************
  mcs_pkg::mcs_fire_t fire_reg;
  logic selfFire;
  logic testFire;
  logic anyFire;
  logic crowbar_reg;
  assign selfFire = phaseOverVolt | groundOverVolt;
  assign testFire = forceTrip & ~selfFire;
  assign anyFire = (selfFire | testFire) & mcs_is_idle(fire_reg);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fire_reg <= mcs_pkg::MCS_IDLE;
    end else begin
      unique case (fire_reg)
        mcs_pkg::MCS_IDLE: begin
          if (selfFire | testFire) begin
            fire_reg <= mcs_pkg::MCS_FIRED;
          end
        end
        mcs_pkg::MCS_FIRED: begin
          // Release only once stopped and no request is still pending
          if (motorStopped & ~selfFire & ~forceTrip) begin
            fire_reg <= mcs_pkg::MCS_IDLE;
          end
        end
        default: fire_reg <= mcs_pkg::MCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crowbar_reg <= 1'b0;
    end else begin
      crowbar_reg <= ~mcs_is_idle(fire_reg) | selfFire | testFire;
    end
  end
  assign crowbarOn = crowbar_reg;

  // ****************************************
  // Ready wait timer
  // ****************************************
  logic [mcs_pkg::CNT_W-1:0] wait_reg;
  logic waitStart;
  logic [mcs_pkg::CNT_W-1:0] waitLoad;
  logic started_reg;
  logic ready_reg;
  logic holdOpen;
  // Power-on wait begins on the first cycle after reset release
  assign waitStart = ~started_reg | anyFire;

  always_comb begin
    if (anyFire & selfFire) begin
      waitLoad = mcs_pkg::CNT_W'(LONG_WAIT);
    end else if (tempAbove40) begin
      waitLoad = mcs_pkg::CNT_W'(LONG_WAIT);
    end else begin
      waitLoad = mcs_pkg::CNT_W'(SHORT_WAIT);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_reg <= '0;
    end else if (waitStart) begin
      wait_reg <= waitLoad;
    end else begin
      wait_reg <= mcs_count_down(wait_reg);
    end
  end

  // A fired crowbar is never reported ready even if the wait has run out
  assign holdOpen = ~started_reg | waitStart | ~mcs_timer_done(wait_reg)
                    | tempAbove60
                    | internalFault
                    | ~mcs_is_idle(fire_reg);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= ~holdOpen;
    end
  end
  assign readyContact = ready_reg;

  // ****************************************
  // Trip indication latch
  // ****************************************
  logic [mcs_pkg::CNT_W-1:0] trip_reg;
  logic tripOn_reg;

  // Each new firing restarts the hold so the contact clears 2 min after the last
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_reg <= '0;
    end else if (anyFire) begin
      trip_reg <= mcs_pkg::CNT_W'(TRIP_HOLD);
    end else begin
      trip_reg <= mcs_count_down(trip_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tripOn_reg <= 1'b0;
    end else begin
      tripOn_reg <= anyFire | (trip_reg > mcs_pkg::CNT_W'(1));
    end
  end
  assign tripContact = tripOn_reg;
endmodule // mcs_supervisor

// ### verif/mcs_supervisor_properties.sv
// Port checker for the crowbar supervisor.
// Assumes it is bound to every supervisor instance.
`timescale 1ns/10ps
module mcs_supervisor_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic phaseOverVolt,
  input wire logic groundOverVolt,
  input wire logic forceTrip,
  input wire logic motorStopped,
  input wire logic tempAbove40,
  input wire logic tempAbove60,
  input wire logic internalFault,
  input wire logic crowbarOn,
  input wire logic readyContact,
  input wire logic tripContact
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  phase_fire_a: assert property (!crowbarOn && phaseOverVolt |=> crowbarOn)
    else $error("phase fire missed");
  ground_fire_a: assert property (!crowbarOn && groundOverVolt |=> crowbarOn)
    else $error("ground fire missed");
  test_fire_a: assert property (!crowbarOn && forceTrip |=> crowbarOn)
    else $error("test fire missed");
  // Release is decided on a stopped motor and shows two edges later
  short_hold_a: assert property ($fell(crowbarOn) |-> $past(motorStopped, 2))
    else $error("short released early");
  trip_latch_a: assert property ($rose(crowbarOn) |-> tripContact)
    else $error("trip contact late");
  fired_ready_a: assert property (crowbarOn |-> !readyContact)
    else $error("ready while fired");
  ready_wait_a: assert property ($rose(crowbarOn) |-> !readyContact [*8])
    else $error("ready wait short");
  fault_open_a: assert property (internalFault |=> !readyContact)
    else $error("ready during fault");
  hot_open_a: assert property (tempAbove60 |=> !readyContact)
    else $error("ready while hot");
endmodule // mcs_supervisor_properties
bind mcs_supervisor mcs_supervisor_properties u_props (
  .clk(clk),
  .rst_b(rst_b),
  .phaseOverVolt(phaseOverVolt),
  .groundOverVolt(groundOverVolt),
  .forceTrip(forceTrip),
  .motorStopped(motorStopped),
  .tempAbove40(tempAbove40),
  .tempAbove60(tempAbove60),
  .internalFault(internalFault),
  .crowbarOn(crowbarOn),
  .readyContact(readyContact),
  .tripContact(tripContact)
);

// ### verif/mcs_motor_model.sv
// Motor and drive controller facing the supervisor.
// Assumes the bench gives the coast-down delay of each firing.
`timescale 1ns/10ps
module mcs_motor_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic crowbarOn,
  input wire logic readyContact,
  input wire logic [2:0] stopDly,
  output logic motorStopped
);
  logic [3:0] coast_reg;
  // Controller restarts the motor only once ready is back
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coast_reg <= '0;
      motorStopped <= 1'b0;
    end else if (crowbarOn) begin
      coast_reg <= coast_reg + 4'h1;
      if (coast_reg > {1'b0, stopDly}) begin
        motorStopped <= 1'b1;
      end
    end else if (readyContact) begin
      coast_reg <= '0;
      motorStopped <= 1'b0;
    end
  end
endmodule // mcs_motor_model

// ### verif/mcs_supervisor_tb.sv
// Bench for the crowbar supervisor with short wait parameters.
// Assumes the motor model answers each firing.
`timescale 1ns/10ps
module mcs_supervisor_tb;
  logic clk = 0, rst_b = 0, phaseOverVolt = 0, groundOverVolt = 0, forceTrip = 0;
  logic tempAbove40 = 0, tempAbove60 = 0, internalFault = 0;
  logic motorStopped, crowbarOn, readyContact, tripContact;
  logic [2:0] stopDly = 3'h0;
  logic [31:0] lfsr = 32'hca17;
  logic [5:0] q[$];
  logic [5:0] e;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  // Scenarios take about 550 cycles; the ceiling leaves ample margin
  localparam int TIMEOUT_CYC = 1000;
  event smp;
  initial forever #50 clk = ~clk;
  mcs_supervisor #(
    .SHORT_WAIT(20),
    .LONG_WAIT(50),
    .TRIP_HOLD(80)
  ) DUT (
    .clk(clk),
    .rst_b(rst_b),
    .phaseOverVolt(phaseOverVolt),
    .groundOverVolt(groundOverVolt),
    .forceTrip(forceTrip),
    .motorStopped(motorStopped),
    .tempAbove40(tempAbove40),
    .tempAbove60(tempAbove60),
    .internalFault(internalFault),
    .crowbarOn(crowbarOn),
    .readyContact(readyContact),
    .tripContact(tripContact)
  );
  mcs_motor_model u_motor (
    .clk(clk),
    .rst_b(rst_b),
    .crowbarOn(crowbarOn),
    .readyContact(readyContact),
    .stopDly(stopDly),
    .motorStopped(motorStopped)
  );
  task automatic check(logic [2:0] seen, logic [2:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t outputs %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Wait n edges, then note a mask and an expected value
  task automatic at(int n, logic [5:0] me);
    repeat (n) @(posedge clk);
    #1 q.push_back(me);
    -> smp;
  endtask
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Checks sit on the last cycle of each wait and the first cycle after it
  task automatic fire(logic [2:0] src, logic w, int ln);
    lfsr = lfsr_step(lfsr);
    stopDly = lfsr[2:0];
    tempAbove40 = w;
    {forceTrip, phaseOverVolt, groundOverVolt} = src;
    at(1, 6'h3d);
    {forceTrip, phaseOverVolt, groundOverVolt} = 3'h0;
    at(1, 6'h3d);
    at(ln - 1, 6'h10);
    at(1, 6'h32);
    at(78 - ln, 6'h09);
    at(1, 6'h08);
    $display("Firing %b done", src);
  endtask
  always @(smp) begin
    e = q.pop_front();
    check({crowbarOn, readyContact, tripContact} & e[5:3], e[2:0]);
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > TIMEOUT_CYC) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_b = 1;
    at(21, 6'h38);
    at(1, 6'h3a);
    $display("Power-on wait done");
    fire(3'h4, 0, 20);
    fire(3'h4, 1, 50);
    fire(3'h2, 0, 50);
    fire(3'h1, 0, 50);
    fire(3'h6, 0, 50);
    for (int i = 0; i < 2; i++) begin
      {tempAbove40, tempAbove60, internalFault} = i ? 3'h1 : 3'h6;
      at(30, 6'h10);
      {tempAbove40, tempAbove60, internalFault} = 3'h0;
      at(1, 6'h12);
      $display("Level test %0d done", i);
    end
    // Mid-run reset with a warm base takes the long power-on wait
    tempAbove40 = 1'b1;
    rst_b = 1'b0;
    at(1, 6'h38);
    rst_b = 1'b1;
    at(51, 6'h10);
    at(1, 6'h12);
    $display("Reset wait done");
    @(posedge clk);
    end_of_test();
  end
endmodule // mcs_supervisor_tb
